// File: src/cccr_pkg.sv
package cccr_pkg;

    // Register indices on the plain register port.
    localparam logic [7:0]  CCCR_ADDR_CFG      = 8'h13;
    localparam logic [7:0]  CCCR_ADDR_OFS_HIGH = 8'h14;
    localparam logic [7:0]  CCCR_ADDR_OFS_LOW  = 8'h15;
    localparam logic [7:0]  CCCR_ADDR_GAIN_HIGH = 8'h16;
    localparam logic [7:0]  CCCR_ADDR_GAIN_LOW = 8'h17;

    // Reset values.
    localparam logic [15:0] CCCR_RST_CFG       = 16'h0000;
    localparam logic [15:0] CCCR_RST_OFS_HIGH  = 16'h0000;
    localparam logic [15:0] CCCR_RST_OFS_LOW   = 16'h0000;
    localparam logic [15:0] CCCR_RST_GAIN_HIGH = 16'h8000;
    localparam logic [15:0] CCCR_RST_GAIN_LOW  = 16'h0000;

    // Bits of the configuration and low registers that hold storage.
    localparam logic [15:0] CCCR_CFG_RW_MASK   = 16'hffc7;
    localparam logic [15:0] CCCR_LOW_RW_MASK   = 16'hff00;
    localparam int          CCCR_SEL_LSB       = 0;
    localparam int          CCCR_SEL_W         = 2;
    localparam int          CCCR_TRIM_W        = 24;

    typedef enum logic [3:0] {
        CCCR_SRC_NORMAL   = 4'h1,
        CCCR_SRC_SHORTED  = 4'h2,
        CCCR_SRC_TEST_POS = 4'h4,
        CCCR_SRC_TEST_NEG = 4'h8
    } cccr_source_t;

endpackage : cccr_pkg

// File: src/cccr_regs.sv
// Our own choice: strobed register access.
`timescale 1ns/100ps
// Functional notes
// - Selector 0 normal pair, 1 shorted inputs, 2 positive test, 3 negative.
// - Configuration register resets to zero, selecting the normal input pair.
// - Offset high register holds offset bits 23..8, two's complement.
// - Offset low register upper byte holds offset bits 7..0.
// - Offset low register low byte always reads zero.
// - Gain high register holds unsigned gain bits 23..8, range 0 to 2.
// - Gain high register resets to 8000, gain of exactly one.
// - Gain low register upper byte holds gain bits 7..0, low byte zero.
// - Offset high register resets to zero.
module cccr_regs
    import cccr_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic               ref_clk,
    input  wire logic               reset,
    input  wire logic               clk_en,
    // Register port.
    input  wire logic [7:0]         reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [15:0]        reg_rdata,
    // Signal path.
    output logic      [1:0]         input_source_select,
    output logic      [3:0]         source_route,
    output logic      [23:0]        offset_trim,
    output logic      [23:0]        gain_trim
);

    logic [15:0] cfg_r;
    logic [15:0] ofs_high_r;
    logic [15:0] ofs_low_r;
    logic [15:0] gain_high_r;
    logic [15:0] gain_low_r;
    logic [15:0] rdata_nxt;
    cccr_source_t route_nxt;

    // Configuration register; reserved bits 5:3 hold no storage.
    // reset to zero
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            cfg_r <= CCCR_RST_CFG;
        else if (clk_en && reg_wr && reg_addr == CCCR_ADDR_CFG)
            cfg_r <= reg_wdata & CCCR_CFG_RW_MASK;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            ofs_high_r <= CCCR_RST_OFS_HIGH;
        else if (clk_en && reg_wr && reg_addr == CCCR_ADDR_OFS_HIGH)
            ofs_high_r <= reg_wdata;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            ofs_low_r <= CCCR_RST_OFS_LOW;
        else if (clk_en && reg_wr && reg_addr == CCCR_ADDR_OFS_LOW)
            ofs_low_r <= reg_wdata & CCCR_LOW_RW_MASK;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            gain_high_r <= CCCR_RST_GAIN_HIGH;
        else if (clk_en && reg_wr && reg_addr == CCCR_ADDR_GAIN_HIGH)
            gain_high_r <= reg_wdata;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            gain_low_r <= CCCR_RST_GAIN_LOW;
        else if (clk_en && reg_wr && reg_addr == CCCR_ADDR_GAIN_LOW)
            gain_low_r <= reg_wdata & CCCR_LOW_RW_MASK;
    end

    // Unmapped addresses read as zero so software sees a defined answer.
    always_comb
    begin
        case (reg_addr)
            CCCR_ADDR_CFG:       rdata_nxt = cfg_r;
            CCCR_ADDR_OFS_HIGH:  rdata_nxt = ofs_high_r;
            CCCR_ADDR_OFS_LOW:   rdata_nxt = ofs_low_r;
            CCCR_ADDR_GAIN_HIGH: rdata_nxt = gain_high_r;
            CCCR_ADDR_GAIN_LOW:  rdata_nxt = gain_low_r;
            default:             rdata_nxt = 16'h0000;
        endcase
    end

    // Read data stands in the cycle after an enabled strobe and is held while the clock enable is low.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            reg_rdata <= 16'h0000;
        else if (clk_en)
            reg_rdata <= reg_rd ? rdata_nxt : 16'h0000;
    end

    always_comb
    begin
        case (cfg_r[CCCR_SEL_LSB +: CCCR_SEL_W])
            2'h0:    route_nxt = CCCR_SRC_NORMAL;
            2'h1:    route_nxt = CCCR_SRC_SHORTED;
            2'h2:    route_nxt = CCCR_SRC_TEST_POS;
            2'h3:    route_nxt = CCCR_SRC_TEST_NEG;
            default: route_nxt = CCCR_SRC_NORMAL;
        endcase
    end

    // Outputs are registered copies, one cycle behind the storage.
    // selector outputs
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            input_source_select <= CCCR_RST_CFG[CCCR_SEL_LSB +: CCCR_SEL_W];
            source_route        <= CCCR_SRC_NORMAL;
        end
        else if (clk_en)
        begin
            input_source_select <= cfg_r[CCCR_SEL_LSB +: CCCR_SEL_W];
            source_route        <= route_nxt;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            offset_trim <= {CCCR_RST_OFS_HIGH, CCCR_RST_OFS_LOW[15:8]};
        else if (clk_en)
            offset_trim <= {ofs_high_r, ofs_low_r[15:8]};
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            gain_trim <= {CCCR_RST_GAIN_HIGH, CCCR_RST_GAIN_LOW[15:8]};
        else if (clk_en)
            gain_trim <= {gain_high_r, gain_low_r[15:8]};
    end

    AST_ROUTE_MATCH: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en |=> source_route ==
            (4'h1 << $past(cfg_r[CCCR_SEL_LSB +: CCCR_SEL_W])))
        else $error("source route does not follow selector");

    AST_SEL_FOLLOW: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en |=> input_source_select ==
            $past(cfg_r[CCCR_SEL_LSB +: CCCR_SEL_W]))
        else $error("selector output does not follow register");

    AST_SEL_STORE: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_wr && reg_addr == CCCR_ADDR_CFG |=>
        cfg_r[CCCR_SEL_LSB +: CCCR_SEL_W] ==
            $past(reg_wdata[CCCR_SEL_LSB +: CCCR_SEL_W]))
        else $error("selector write not stored");

    AST_SEL_READ: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_rd && reg_addr == CCCR_ADDR_CFG |=>
        reg_rdata[CCCR_SEL_LSB +: CCCR_SEL_W] ==
            $past(cfg_r[CCCR_SEL_LSB +: CCCR_SEL_W]))
        else $error("selector read back wrong");

    AST_CFG_RESET: assert property (
        @(posedge ref_clk) reset |=> cfg_r == CCCR_RST_CFG)
        else $error("configuration not cleared by reset");

    AST_ROUTE_RESET: assert property (
        @(posedge ref_clk)
        reset |=> source_route == CCCR_SRC_NORMAL &&
            input_source_select == CCCR_RST_CFG[CCCR_SEL_LSB +: CCCR_SEL_W])
        else $error("channel not on normal inputs after reset");

    AST_CFG_RESERVED_READ: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_rd && reg_addr == CCCR_ADDR_CFG |=>
        (reg_rdata & ~CCCR_CFG_RW_MASK) == 16'h0000)
        else $error("configuration reserved bits not zero");

    AST_OFS_HIGH_STORE: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_wr && reg_addr == CCCR_ADDR_OFS_HIGH |=>
        ofs_high_r == $past(reg_wdata))
        else $error("offset high write not stored");

    AST_OFS_HIGH_READ: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_rd && reg_addr == CCCR_ADDR_OFS_HIGH |=>
        reg_rdata == $past(ofs_high_r))
        else $error("offset high read back wrong");

    // Trim outputs trail a write by two edges; when the clock enable was
    // low on the middle edge the copy waits, so those checks stand aside.
    AST_OFS_HIGH_WRITE: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_wr && reg_addr == CCCR_ADDR_OFS_HIGH |=> ##1
        (!$past(clk_en) || offset_trim[23:8] == $past(reg_wdata, 2)))
        else $error("offset high bits not assembled");

    AST_OFS_LOW_STORE: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_wr && reg_addr == CCCR_ADDR_OFS_LOW |=>
        ofs_low_r[15:8] == $past(reg_wdata[15:8]))
        else $error("offset low write not stored");

    AST_OFS_LOW_READ: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_rd && reg_addr == CCCR_ADDR_OFS_LOW |=>
        reg_rdata[15:8] == $past(ofs_low_r[15:8]))
        else $error("offset low read back wrong");

    AST_OFS_LOW_WRITE: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_wr && reg_addr == CCCR_ADDR_OFS_LOW |=> ##1
        (!$past(clk_en) || offset_trim[7:0] == $past(reg_wdata[15:8], 2)))
        else $error("offset low byte not assembled");

    AST_OFS_LOW_ZERO: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_rd && reg_addr == CCCR_ADDR_OFS_LOW |=>
        reg_rdata[7:0] == 8'h00)
        else $error("offset low reserved byte not zero");

    AST_OFS_LOW_EMPTY: assert property (
        @(posedge ref_clk) disable iff (reset)
        (ofs_low_r & ~CCCR_LOW_RW_MASK) == 16'h0000)
        else $error("offset low reserved byte holds data");

    AST_GAIN_HIGH_STORE: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_wr && reg_addr == CCCR_ADDR_GAIN_HIGH |=>
        gain_high_r == $past(reg_wdata))
        else $error("gain high write not stored");

    AST_GAIN_HIGH_READ: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_rd && reg_addr == CCCR_ADDR_GAIN_HIGH |=>
        reg_rdata == $past(gain_high_r))
        else $error("gain high read back wrong");

    AST_GAIN_HIGH_WRITE: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_wr && reg_addr == CCCR_ADDR_GAIN_HIGH |=> ##1
        (!$past(clk_en) || gain_trim[23:8] == $past(reg_wdata, 2)))
        else $error("gain high bits not assembled");

    AST_GAIN_RESET: assert property (
        @(posedge ref_clk) reset |=> gain_high_r == CCCR_RST_GAIN_HIGH)
        else $error("gain high reset wrong");

    AST_GAIN_TRIM_RESET: assert property (
        @(posedge ref_clk)
        reset |=> gain_trim == {CCCR_RST_GAIN_HIGH, CCCR_RST_GAIN_LOW[15:8]})
        else $error("gain trim not one after reset");

    AST_GAIN_LOW_STORE: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_wr && reg_addr == CCCR_ADDR_GAIN_LOW |=>
        gain_low_r[15:8] == $past(reg_wdata[15:8]))
        else $error("gain low write not stored");

    AST_GAIN_LOW_READ: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_rd && reg_addr == CCCR_ADDR_GAIN_LOW |=>
        reg_rdata[15:8] == $past(gain_low_r[15:8]))
        else $error("gain low read back wrong");

    AST_GAIN_LOW_WRITE: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_wr && reg_addr == CCCR_ADDR_GAIN_LOW |=> ##1
        (!$past(clk_en) || gain_trim[7:0] == $past(reg_wdata[15:8], 2)))
        else $error("gain low byte not assembled");

    AST_GAIN_LOW_ZERO: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_rd && reg_addr == CCCR_ADDR_GAIN_LOW |=>
        reg_rdata[7:0] == 8'h00)
        else $error("gain low reserved byte not zero");

    AST_GAIN_LOW_EMPTY: assert property (
        @(posedge ref_clk) disable iff (reset)
        (gain_low_r & ~CCCR_LOW_RW_MASK) == 16'h0000)
        else $error("gain low reserved byte holds data");

    AST_OFS_RESET: assert property (
        @(posedge ref_clk) reset |=> ##1 offset_trim == 24'h000000)
        else $error("offset trim not zero after reset");

    AST_OFS_HIGH_RESET: assert property (
        @(posedge ref_clk) reset |=> ofs_high_r == CCCR_RST_OFS_HIGH)
        else $error("offset high reset wrong");

    AST_RDATA_RESET: assert property (
        @(posedge ref_clk) reset |=> reg_rdata == 16'h0000)
        else $error("read data not cleared by reset");

    AST_RDATA_IDLE: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero without a read");

    AST_UNMAPPED_READ: assert property (
        @(posedge ref_clk) disable iff (reset)
        clk_en && reg_rd &&
        (reg_addr < CCCR_ADDR_CFG || reg_addr > CCCR_ADDR_GAIN_LOW) |=>
        reg_rdata == 16'h0000)
        else $error("unmapped read not zero");

    // A low clock enable freezes every flop, read data included, so a read
    // answer that meets a stall is held rather than lost.
    AST_HOLD_READ_DATA: assert property (
        @(posedge ref_clk) disable iff (reset)
        !clk_en |=> $stable(reg_rdata))
        else $error("read data moved while clock enable low");

    AST_HOLD_OUTPUTS: assert property (
        @(posedge ref_clk) disable iff (reset)
        !clk_en |=> $stable(offset_trim) && $stable(gain_trim) &&
            $stable(source_route) && $stable(input_source_select))
        else $error("outputs moved while clock enable low");

    AST_HOLD_STORAGE: assert property (
        @(posedge ref_clk) disable iff (reset)
        !clk_en |=> $stable(cfg_r) && $stable(ofs_high_r) &&
            $stable(ofs_low_r) && $stable(gain_high_r) &&
            $stable(gain_low_r))
        else $error("storage moved while clock enable low");

endmodule : cccr_regs

// File: test/tb_cccr_regs.sv
`timescale 1ns/100ps
module tb_cccr_regs
    import cccr_pkg::*;
();
    logic        ref_clk   = 1'b0;
    logic        reset     = 1'b1;
    logic        clk_en    = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [15:0] reg_rdata;
    logic [1:0]  input_source_select;
    logic [3:0]  source_route;
    logic [23:0] offset_trim;
    logic [23:0] gain_trim;
    int          num_errors  = 0;
    int          check_count = 0;

    always #2 ref_clk = ~ref_clk;

    cccr_regs i_dut (
        .ref_clk, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .input_source_select, .source_route,
        .offset_trim, .gain_trim
    );

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_rd    <= 1'b0;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // The read data stand in the cycle after the strobe and are held while the clock enable is low.
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wr   <= 1'b0;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        check({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd_chk

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask : idle

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        rd_chk(CCCR_ADDR_CFG, 16'h0000);
        rd_chk(CCCR_ADDR_OFS_HIGH, 16'h0000);
        rd_chk(CCCR_ADDR_OFS_LOW, 16'h0000);
        rd_chk(CCCR_ADDR_GAIN_HIGH, 16'h8000);
        rd_chk(CCCR_ADDR_GAIN_LOW, 16'h0000);
        check(gain_trim, 24'h800000);
        check(24'(source_route), 24'h000001);
        $display("Test reset values done");
        for (int i = 0; i < 4; i++)
        begin
            wr(CCCR_ADDR_CFG, 16'h0038 | 16'(i));
            idle(3);
            @(negedge ref_clk);
            check(24'(input_source_select), 24'(i));
            check(24'(source_route), 24'h000001 << i);
        end
        rd_chk(CCCR_ADDR_CFG, 16'h0003);
        $display("Test source select done");
        wr(CCCR_ADDR_OFS_HIGH, 16'hfedc);
        wr(CCCR_ADDR_OFS_LOW, 16'hbaff);
        wr(CCCR_ADDR_GAIN_HIGH, 16'h1234);
        wr(CCCR_ADDR_GAIN_LOW, 16'h56ff);
        rd_chk(CCCR_ADDR_OFS_HIGH, 16'hfedc);
        rd_chk(CCCR_ADDR_OFS_LOW, 16'hba00);
        rd_chk(CCCR_ADDR_GAIN_LOW, 16'h5600);
        idle(1);
        @(negedge ref_clk);
        check(24'(reg_rdata), 24'h000000);
        check(offset_trim, 24'hfedcba);
        check(gain_trim, 24'h123456);
        $display("Test trim words done");
        wr(8'h18, 16'hffff);
        rd_chk(8'h18, 16'h0000);
        rd_chk(CCCR_ADDR_GAIN_HIGH, 16'h1234);
        // A write while the clock enable is low must be lost.
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(CCCR_ADDR_GAIN_HIGH, 16'h0001);
        idle(2);
        clk_en <= 1'b1;
        rd_chk(CCCR_ADDR_GAIN_HIGH, 16'h1234);
        check(gain_trim, 24'h123456);
        $display("Test unmapped and enable done");
        @(posedge ref_clk);
        reset <= 1'b1;
        idle(2);
        reset <= 1'b0;
        @(negedge ref_clk);
        check(gain_trim, 24'h800000);
        check(offset_trim, 24'h000000);
        check(24'(source_route), 24'h000001);
        check(24'(input_source_select), 24'h000000);
        rd_chk(CCCR_ADDR_CFG, 16'h0000);
        $display("Test second reset done");
        complete_run();
    end
endmodule : tb_cccr_regs
